// ### hw/scp_pkg.sv
// scp_pkg: constants, types and helper functions of the serial control port
// assumes: system logic on mclk at 100 MHz, link logic on the master's serial clock
// Summary of operation
// [R1] a framed access must hold exactly 16 clocks; otherwise discard it, flag serial failure
// [R2] in start-up or restart mode a clock-count failure forces a system reset instead
// [R3] input bits are taken on falling serial clock edges, output changes on rising edges
// [R4] master idles the serial clock low and frames each access with select low
// [R5] serial data output floats whenever select is high
// [R6] full duplex: feedback data shifts out while control data shifts in
// [R7] each access is a 4-bit header then 12 data bits
// [R8] read-only header bit set: read feedback, change nothing; write only when clear
// [R9] address 00 always writes mode/watchdog; reads status or fault report
// [R10] address 01 in normal, standby, flash writes irq enable; reads enable or pending flags
// [R11] address 01 in start-up or restart writes special mode; reads enable or special
// [R12] address 10 writes setup or scratch 0 by mode; reads setup or scratch 0
// [R13] address 11 writes phy control or scratch 1 by mode; reads phy or scratch 1
// [R14] every software-writable control bit reads back through a feedback register; the code returns neither the watchdog period code nor the written mode field
// [R15] a forbidden operating-mode transition forces an immediate system reset
// [R16] undefined mode or watchdog period code forces an immediate system reset
// [R17] irq pin pulled low while any pending flag is set, released otherwise
// [R18] reading the pending flags clears them; reset output low clears them too
// [R19] irq pin stays released for the minimum high time after each read
// [R20] a pending interrupt not read within the readout timeout forces a system reset
// [R21] in normal mode rate-limited sources fire at most once per watchdog period
// [R22] bus short to ground, short to battery, transmit clamp flag on every change
// [R23] header bits 15..14 address, 13 feedback select, 12 read-only flag
// [R24] bits shift most significant first, address bits go first
package scp_pkg;

	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] HDR_BITS   = 5'h04;
	localparam int         DATA_BITS  = 12;
	localparam int POS_ADDR_HI = 15;
	localparam int POS_ADDR_LO = 14;
	localparam int POS_FB_SEL  = 13;
	localparam int POS_RO      = 12;

	localparam logic [1:0] ADDR_MODE  = 2'h0;
	localparam logic [1:0] ADDR_IRQ   = 2'h1;
	localparam logic [1:0] ADDR_SETUP = 2'h2;
	localparam logic [1:0] ADDR_PHY   = 2'h3;

	// mode/watchdog word fields
	localparam int MW_NWP_HI = 11;
	localparam int MW_NWP_LO = 6;
	localparam int MW_OM_HI  = 5;
	localparam int MW_OM_LO  = 3;
	localparam int MW_SDM    = 2;
	localparam int MW_EN     = 1;

	localparam logic [2:0] OM_NORMAL      = 3'h1;
	localparam logic [2:0] OM_STANDBY     = 3'h2;
	localparam logic [2:0] OM_INIT_FLASH  = 3'h3;
	localparam logic [2:0] OM_SLEEP       = 3'h4;
	localparam logic [2:0] OM_INIT_NORMAL = 3'h5;
	localparam logic [2:0] OM_LEAVE_FLASH = 3'h6;
	localparam logic [2:0] OM_FLASH       = 3'h7;

	// pending flag positions
	localparam int IRQ_SPI    = 0;
	localparam int IRQ_GND    = 1;
	localparam int IRQ_TXD    = 3;
	localparam int IRQ_EXT_LO = 4;
	localparam int EXT_IRQS   = 8;

	localparam logic [3:0] RSRC_POWER = 4'h0;
	localparam logic [3:0] RSRC_SPI   = 4'h1;
	localparam logic [3:0] RSRC_MODE  = 4'h2;
	localparam logic [3:0] RSRC_IRQTO = 4'h3;

	localparam logic [11:0] REG_RST = 12'h000;

	localparam int CLK_PERIOD_NS    = 10;
	localparam int IRQ_MIN_HIGH_NS  = 1000;
	localparam int IRQ_MIN_HIGH_CYC = (IRQ_MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IRQ_READOUT_MS   = 256;
	localparam int IRQ_READOUT_CYC  = IRQ_READOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RESET_LEN_CYC    = 16;

	typedef enum logic [2:0] {
		SCP_STARTUP, SCP_RESTART, SCP_NORMAL, SCP_STANDBY, SCP_FLASH, SCP_SLEEP
	} scp_mode_t;

	typedef struct packed {
		logic [1:0]  addr;
		logic        fb_sel;
		logic        ro;
		logic [11:0] data;
	} scp_frame_t;

	typedef struct packed {
		logic      ok;
		scp_mode_t mode;
	} scp_step_t;

	function automatic logic scp_nwp_valid(input logic [5:0] c);
		case (c)
			6'h09, 6'h0C, 6'h12, 6'h14, 6'h1B, 6'h24, 6'h2D, 6'h33, 6'h35, 6'h36: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// permitted mode steps of the system controller
	function automatic scp_step_t scp_step(input scp_mode_t cur, input logic [2:0] om);
		scp_step_t s;
		s.ok   = 1'b0;
		s.mode = cur;
		case (cur)
			SCP_STARTUP, SCP_RESTART: begin
				if (om == OM_INIT_NORMAL) s = '{1'b1, SCP_NORMAL};
				if (om == OM_INIT_FLASH) s = '{1'b1, SCP_FLASH};
			end
			SCP_NORMAL, SCP_STANDBY: begin
				if (om == OM_NORMAL) s = '{1'b1, SCP_NORMAL};
				if (om == OM_STANDBY) s = '{1'b1, SCP_STANDBY};
				if (om == OM_SLEEP) s = '{1'b1, SCP_SLEEP};
			end
			SCP_FLASH: begin
				if (om == OM_FLASH) s = '{1'b1, SCP_FLASH};
				if (om == OM_LEAVE_FLASH) s = '{1'b1, SCP_RESTART};
			end
			SCP_SLEEP: begin
				if (om == OM_NORMAL) s = '{1'b1, SCP_NORMAL};
			end
			default: s.ok = 1'b0;
		endcase
		return s;
	endfunction

endpackage

// ### hw/scp_serial_port.sv
// scp_serial_port: serial control port, register file, irq pin and forced-reset logic
// assumes: sclk comes from the master and stands still outside frames; select high
// lasts at least 40 ns between frames so mclk can collect the finished word
module scp_serial_port #(
	parameter int READOUT_CYC = scp_pkg::IRQ_READOUT_CYC,
	parameter int RESET_LEN   = scp_pkg::RESET_LEN_CYC,
	parameter logic [11:0] RATE_MASK = 12'hFF0
) (
	// system clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// serial link
	input  wire logic                  sclk,
	input  wire logic                  serial_select_n,
	input  wire logic                  serial_data_in,
	output logic                       serial_data_out,
	output logic                       serial_data_out_oe,
	// open-drain interrupt pin
	input  wire logic                  irq_out_n_i,
	output logic                       irq_out_n_o,
	output logic                       irq_out_n_oe,
	// system reset output
	output logic                       system_reset_out_n,
	// chip-side events and status
	input  wire logic [scp_pkg::EXT_IRQS-1:0] irq_src_pulse,
	input  wire logic [2:0]            bus_fault_lvl,
	input  wire logic [8:0]            diag_in,
	input  wire logic                  wd_period_tick,
	// chip-side controls
	output scp_pkg::scp_mode_t         op_mode,
	output logic [5:0]                 wd_period_code,
	output logic                       wd_service,
	output logic                       enable_out,
	output logic                       sdm_out,
	output logic [11:0]                special_ctrl,
	output logic [11:0]                setup_ctrl,
	output logic [11:0]                phy_ctrl
);

	// link domain (sclk and select edges)
	logic        start_tog_q;
	logic        seen_tog_q;
	logic [4:0]  fall_cnt_q;
	logic [15:0] rx_q;
	logic [11:0] tx_q;
	logic        tx_live_q;
	logic        in_frame;
	logic [11:0] shadow_q [8];

	// flips once per frame so the first falling edge knows a new frame began
	always_ff @(negedge serial_select_n or negedge rst_n) begin
		if (!rst_n)
			start_tog_q <= 1'b0;
		else
			start_tog_q <= ~start_tog_q; // [R4]
	end

	assign in_frame = (seen_tog_q == start_tog_q);

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			seen_tog_q <= 1'b0;
			fall_cnt_q <= 5'h00;
			rx_q       <= 16'h0000;
		end else begin
			seen_tog_q <= start_tog_q;
			if (!in_frame)
				fall_cnt_q <= 5'h01;
			else if (fall_cnt_q != 5'h1F)
				fall_cnt_q <= fall_cnt_q + 5'h01;
			rx_q <= {rx_q[14:0], serial_data_in}; // [R3] [R24]
		end
	end

	// feedback word is loaded once the header is in; header slots return zero
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q      <= 12'h000;
			tx_live_q <= 1'b0;
		end else begin
			tx_live_q <= in_frame && (fall_cnt_q >= scp_pkg::HDR_BITS);
			if (in_frame && fall_cnt_q == scp_pkg::HDR_BITS)
				tx_q <= shadow_q[rx_q[3:1]]; // [R6] [R7]
			else
				tx_q <= {tx_q[10:0], 1'b0}; // [R3] [R24]
		end
	end

	assign serial_data_out    = tx_live_q & in_frame & tx_q[11];
	assign serial_data_out_oe = ~serial_select_n; // [R5]

	// system domain
	logic              sel_s1_q, sel_s2_q, sel_s3_q;
	logic              pin_s1_q, pin_s2_q;
	scp_pkg::scp_mode_t mode_q;
	logic [11:0]       mode_word_q, irq_en_q, special_q, setup_q, scratch0_q, scratch1_q;
	logic [11:0]       phy_q, irq_q, irq_d, irq_set, rate_fired_q;
	logic [2:0]        fault_prev_q;
	logic [15:0]       hold_q, hold_d, since_read_q;
	logic [31:0]       pend_q;
	logic [15:0]       rst_cnt_q;
	logic [3:0]        rst_src_q, rst_src_d;
	logic              irq_oe_q, wd_service_q, rst_out_q;
	scp_pkg::scp_frame_t frm;
	scp_pkg::scp_step_t step;
	logic              frame_end, acc_ok, spi_fail, boot, wr, mode_wr, irq_read;
	logic              bad_code, bad_trans, timeout, reset_req;
	logic [11:0]       status_word, fault_word;
	logic [2:0]        mode_code;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sel_s3_q <= 1'b1;
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			sel_s1_q <= serial_select_n;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
			pin_s1_q <= irq_out_n_i;
			pin_s2_q <= pin_s1_q;
		end
	end

	always_comb begin
		frame_end = sel_s2_q & ~sel_s3_q;
		// link flops are quiet here: select is high and sclk idles
		frm.addr   = rx_q[scp_pkg::POS_ADDR_HI:scp_pkg::POS_ADDR_LO]; // [R23]
		frm.fb_sel = rx_q[scp_pkg::POS_FB_SEL];
		frm.ro     = rx_q[scp_pkg::POS_RO];
		frm.data   = rx_q[scp_pkg::DATA_BITS-1:0];
		acc_ok     = in_frame && (fall_cnt_q == scp_pkg::FRAME_BITS); // [R1]
		spi_fail   = frame_end && !acc_ok; // [R1]
		boot       = (mode_q == scp_pkg::SCP_STARTUP) || (mode_q == scp_pkg::SCP_RESTART);
		wr         = frame_end && acc_ok && !frm.ro && rst_out_q; // [R8]
		mode_wr    = wr && (frm.addr == scp_pkg::ADDR_MODE); // [R9]
		step       = scp_pkg::scp_step(mode_q, frm.data[scp_pkg::MW_OM_HI:scp_pkg::MW_OM_LO]);
		bad_code   = !scp_pkg::scp_nwp_valid(frm.data[scp_pkg::MW_NWP_HI:scp_pkg::MW_NWP_LO])
			|| (frm.data[scp_pkg::MW_OM_HI:scp_pkg::MW_OM_LO] == 3'h0); // [R16]
		bad_trans  = !step.ok; // [R15]
		// flags clear on read with or without the read-only bit
		irq_read   = frame_end && acc_ok && (frm.addr == scp_pkg::ADDR_IRQ) && frm.fb_sel
			&& !boot; // [R10]
		timeout    = (pend_q >= 32'(READOUT_CYC)); // [R20]
		reset_req  = (spi_fail && boot) || (mode_wr && (bad_code || bad_trans)) || timeout;
		rst_src_d  = rst_src_q;
		if (timeout)
			rst_src_d = scp_pkg::RSRC_IRQTO;
		if (mode_wr && (bad_code || bad_trans))
			rst_src_d = scp_pkg::RSRC_MODE; // [R15] [R16]
		if (spi_fail && boot)
			rst_src_d = scp_pkg::RSRC_SPI; // [R2]
	end

	// pending flags; a set in the clearing cycle survives
	always_comb begin
		irq_set = 12'h000;
		irq_set[scp_pkg::IRQ_SPI] = spi_fail && !boot && irq_en_q[scp_pkg::IRQ_SPI]; // [R1] [R2]
		irq_set[scp_pkg::IRQ_TXD:scp_pkg::IRQ_GND] =
			(bus_fault_lvl ^ fault_prev_q) & irq_en_q[scp_pkg::IRQ_TXD:scp_pkg::IRQ_GND]; // [R22]
		irq_set[11:scp_pkg::IRQ_EXT_LO] = irq_src_pulse & irq_en_q[11:scp_pkg::IRQ_EXT_LO];
		if (mode_q == scp_pkg::SCP_NORMAL)
			irq_set = irq_set & ~(rate_fired_q & RATE_MASK); // [R21]
		if (!rst_out_q)
			irq_d = 12'h000; // [R18]
		else if (irq_read)
			irq_d = (irq_q & ~shadow_q[3]) | irq_set; // [R18]
		else
			irq_d = irq_q | irq_set;
		if (irq_read)
			hold_d = 16'(scp_pkg::IRQ_MIN_HIGH_CYC); // [R19]
		else if (hold_q != 16'h0000)
			hold_d = hold_q - 16'h0001;
		else
			hold_d = 16'h0000;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q        <= scp_pkg::REG_RST;
			hold_q       <= 16'h0000;
			irq_oe_q     <= 1'b0;
			fault_prev_q <= 3'h0;
			rate_fired_q <= scp_pkg::REG_RST;
		end else begin
			irq_q        <= irq_d;
			hold_q       <= hold_d;
			irq_oe_q     <= (irq_d != 12'h000) && (hold_d == 16'h0000); // [R17] [R19]
			fault_prev_q <= bus_fault_lvl;
			if (wd_period_tick || mode_q != scp_pkg::SCP_NORMAL)
				rate_fired_q <= irq_set; // [R21]
			else
				rate_fired_q <= rate_fired_q | irq_set;
		end
	end

	// readout watchdog on pending flags
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pend_q <= 32'h0000_0000;
		else if (irq_read || irq_q == 12'h000 || !rst_out_q)
			pend_q <= 32'h0000_0000;
		else if (!timeout)
			pend_q <= pend_q + 32'h0000_0001; // [R20]
	end

	// system reset pulse; power-up also starts with it asserted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt_q <= 16'(scp_pkg::RESET_LEN_CYC);
			rst_out_q <= 1'b0;
			rst_src_q <= scp_pkg::RSRC_POWER;
		end else begin
			rst_src_q <= rst_src_d;
			if (reset_req)
				rst_cnt_q <= 16'(RESET_LEN); // [R2] [R15] [R16] [R20]
			else if (rst_cnt_q != 16'h0000)
				rst_cnt_q <= rst_cnt_q - 16'h0001;
			rst_out_q <= (rst_cnt_q == 16'h0000) && !reset_req;
		end
	end

	// operating mode and mode/watchdog word
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q       <= scp_pkg::SCP_STARTUP;
			mode_word_q  <= scp_pkg::REG_RST;
			wd_service_q <= 1'b0;
		end else begin
			wd_service_q <= mode_wr && !bad_code && !bad_trans; // [R9]
			if (!rst_out_q) begin
				mode_word_q <= scp_pkg::REG_RST;
				if (rst_src_q != scp_pkg::RSRC_POWER)
					mode_q <= scp_pkg::SCP_RESTART;
			end else if (mode_wr && !bad_code && !bad_trans) begin
				mode_word_q <= frm.data; // [R9]
				mode_q      <= step.mode; // [R15]
			end
		end
	end

	// address-decoded control registers, steered by operating mode
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_q   <= scp_pkg::REG_RST;
			special_q  <= scp_pkg::REG_RST;
			setup_q    <= scp_pkg::REG_RST;
			scratch0_q <= scp_pkg::REG_RST;
			phy_q      <= scp_pkg::REG_RST;
			scratch1_q <= scp_pkg::REG_RST;
		end else if (wr) begin
			case (frm.addr)
				scp_pkg::ADDR_IRQ: begin
					if (boot)
						special_q <= frm.data; // [R11]
					else
						irq_en_q <= frm.data; // [R10]
				end
				scp_pkg::ADDR_SETUP: begin
					if (mode_q == scp_pkg::SCP_NORMAL || mode_q == scp_pkg::SCP_STANDBY)
						setup_q <= frm.data; // [R12]
					else
						scratch0_q <= frm.data; // [R12]
				end
				scp_pkg::ADDR_PHY: begin
					if (mode_q == scp_pkg::SCP_NORMAL || mode_q == scp_pkg::SCP_STANDBY)
						phy_q <= frm.data; // [R13]
					else
						scratch1_q <= frm.data; // [R13]
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		case (mode_q)
			scp_pkg::SCP_NORMAL:  mode_code = scp_pkg::OM_NORMAL;
			scp_pkg::SCP_STANDBY: mode_code = scp_pkg::OM_STANDBY;
			scp_pkg::SCP_FLASH:   mode_code = scp_pkg::OM_FLASH;
			scp_pkg::SCP_SLEEP:   mode_code = scp_pkg::OM_SLEEP;
			default:              mode_code = 3'h0;
		endcase
		status_word = {rst_src_q, pin_s2_q, mode_word_q[scp_pkg::MW_SDM:scp_pkg::MW_EN],
			2'h0, mode_code};
		fault_word  = {diag_in, bus_fault_lvl};
	end

	// feedback bank, frozen while select is low so the link reads a still word
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++)
				shadow_q[i] <= 12'h000;
		end else if (sel_s2_q) begin
			shadow_q[0] <= status_word; // [R9]
			shadow_q[1] <= fault_word; // [R9]
			shadow_q[2] <= irq_en_q; // [R10] [R14]
			shadow_q[3] <= boot ? special_q : irq_q; // [R10] [R11]
			shadow_q[4] <= setup_q; // [R12] [R14]
			shadow_q[5] <= scratch0_q; // [R14]
			shadow_q[6] <= phy_q; // [R13] [R14]
			shadow_q[7] <= scratch1_q; // [R14]
		end
	end

	assign irq_out_n_o        = 1'b0;
	assign irq_out_n_oe       = irq_oe_q;
	assign system_reset_out_n = rst_out_q;
	assign op_mode            = mode_q;
	assign wd_period_code     = mode_word_q[scp_pkg::MW_NWP_HI:scp_pkg::MW_NWP_LO];
	assign wd_service         = wd_service_q;
	assign enable_out         = mode_word_q[scp_pkg::MW_EN];
	assign sdm_out            = mode_word_q[scp_pkg::MW_SDM];
	assign special_ctrl       = special_q;
	assign setup_ctrl         = setup_q;
	assign phy_ctrl           = phy_q;

	// cycles since the last flag read, saturating
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			since_read_q <= 16'hFFFF;
		else if (irq_read)
			since_read_q <= 16'h0000;
		else if (since_read_q != 16'hFFFF)
			since_read_q <= since_read_q + 16'h0001;
	end

	count_fail_irq_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
		spi_fail && !boot && irq_en_q[0] && rst_out_q
		&& !(RATE_MASK[0] && rate_fired_q[0] && mode_q == scp_pkg::SCP_NORMAL)
		|=> irq_q[0] && $stable(setup_q) && $stable(mode_word_q))
		else $error("clock-count failure not flagged or not discarded");

	boot_fail_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
		spi_fail && boot |-> ##2 !system_reset_out_n && irq_q[0] == 1'b0)
		else $error("clock-count failure in boot mode did not reset");

	data_out_float_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
		$rose(serial_select_n) |-> !serial_data_out_oe)
		else $error("serial output driven with select high");

	read_only_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
		frame_end && acc_ok && frm.ro && rst_out_q
		|=> $stable(phy_q) && $stable(irq_en_q) && $stable(mode_q))
		else $error("read-only access changed a register");

	bad_trans_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
		mode_wr && bad_trans |-> ##2 !system_reset_out_n ##1 mode_q == scp_pkg::SCP_RESTART)
		else $error("forbidden mode step did not reset");

	bad_code_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
		mode_wr && bad_code |=> $stable(mode_word_q) ##1 !system_reset_out_n)
		else $error("illegal mode word did not reset");

	irq_pin_low_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
		irq_out_n_oe |-> irq_q != 12'h000 && since_read_q >= 16'(scp_pkg::IRQ_MIN_HIGH_CYC))
		else $error("irq pin pulled without pending flags");

	read_clears_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
		irq_read |=> (irq_q & $past(shadow_q[3]) & ~$past(irq_set)) == 12'h000)
		else $error("flag read did not clear flags");

	min_high_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
		since_read_q < 16'(scp_pkg::IRQ_MIN_HIGH_CYC) |-> !irq_out_n_oe)
		else $error("irq pin pulled inside minimum high time");

	readout_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
		timeout |-> ##2 !system_reset_out_n && irq_q == 12'h000)
		else $error("unread interrupt did not reset");

endmodule // scp_serial_port

// ### dv/scp_master_model.sv
// scp_master_model: behavioural serial master for the control port
// assumes: bench calls frame() only while select is high and the link idles
module scp_master_model (
	// serial link
	output logic        sclk,
	output logic        serial_select_n,
	output logic        serial_data_in,
	input  wire logic   serial_data_out,
	input  wire logic   serial_data_out_oe,
	// received word
	output logic [15:0] rx_word,
	output logic        rx_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam realtime HALF = 7.5;

	initial begin
		sclk            = 1'b0;
		serial_select_n = 1'b1;
		serial_data_in  = 1'b0;
		rx_word         = 16'h0000;
		rx_strobe       = 1'b0;
	end

	// nclk other than 16 breaks the frame on purpose; link clock runs only inside frames
	task automatic frame(input logic [15:0] tx, input int nclk);
		logic [15:0] rx;
		rx = 16'h0000;
		serial_select_n = 1'b0;
		#(HALF);
		for (int i = 0; i < nclk; i++) begin
			sclk = 1'b1;
			serial_data_in = tx[15 - (i % 16)];
			#(HALF);
			sclk = 1'b0;
			rx = {rx[14:0], serial_data_out_oe ? serial_data_out : 1'b0};
			#(HALF);
		end
		serial_select_n = 1'b1;
		// released data line must not look like a held bit
		serial_data_in = ~serial_data_in;
		rx_word = rx;
		rx_strobe = 1'b1;
		#1;
		rx_strobe = 1'b0;
		#50;
	endtask
endmodule // scp_master_model

// ### dv/sbc_spi_control_port_with_irq_tb.sv
// sbc_spi_control_port_with_irq_tb: self-checking bench of the serial control port
// assumes: scp_pkg compiled first; master model drives the link at 15 ns
module sbc_spi_control_port_with_irq_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RDO  = 200;
	localparam int RLEN = 4;

	logic                          mclk;
	logic                          rst_n;
	logic                          wd_period_tick;
	logic [scp_pkg::EXT_IRQS-1:0]  irq_src_pulse;
	logic [2:0]                    bus_fault_lvl;
	logic [8:0]                    diag_in;
	logic [11:0]                   r;
	scp_pkg::scp_mode_t            op_mode;
	wire                           sclk, serial_select_n, serial_data_in;
	wire                           serial_data_out, serial_data_out_oe, rx_strobe;
	wire                           irq_out_n_o, irq_out_n_oe, system_reset_out_n, enable_out;
	wire                           wd_service, sdm_out;
	wire [5:0]                     wd_period_code;
	wire [11:0]                    special_ctrl, setup_ctrl, phy_ctrl;
	wire [15:0]                    rx_word;
	int                            num_errors = 0;
	int                            total_checks = 0;
	int                            svc_cnt = 0;
	logic [31:0]                   exp_q[$];

	// open-drain pin with pull-up
	wire irq_out_n_i = irq_out_n_oe ? irq_out_n_o : 1'b1;

	scp_serial_port #(.READOUT_CYC(RDO), .RESET_LEN(RLEN)) u_scp_serial_port (
		.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .serial_select_n(serial_select_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.serial_data_out_oe(serial_data_out_oe), .irq_out_n_i(irq_out_n_i),
		.irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe),
		.system_reset_out_n(system_reset_out_n), .irq_src_pulse(irq_src_pulse),
		.bus_fault_lvl(bus_fault_lvl), .diag_in(diag_in), .wd_period_tick(wd_period_tick),
		.op_mode(op_mode), .wd_period_code(wd_period_code), .wd_service(wd_service),
		.enable_out(enable_out), .sdm_out(sdm_out), .special_ctrl(special_ctrl),
		.setup_ctrl(setup_ctrl), .phy_ctrl(phy_ctrl));

	scp_master_model u_scp_master_model (
		.sclk(sclk), .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
		.rx_word(rx_word), .rx_strobe(rx_strobe));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// one count per accepted mode/watchdog write
	always @(posedge mclk)
		if (wd_service === 1'b1) svc_cnt++;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [15:0] hw(input logic [1:0] a, input logic s, input logic ro,
			input logic [11:0] d);
		return {a, s, ro, d};
	endfunction

	// enable set, development mode and reserved bit clear
	function automatic logic [15:0] md(input logic [2:0] om, input logic [5:0] nwp);
		return {4'h0, nwp, om, 3'h2};
	endfunction

	// header slots read zero whenever data bits are checked
	task automatic xfer(input logic [15:0] w, input int n, input logic [11:0] m,
			input logic [11:0] v);
		exp_q.push_back({{4{|m}}, m, 4'h0, v});
		@(posedge mclk);
		#1;
		u_scp_master_model.frame(w, n);
		repeat (6) @(posedge mclk);
		#1;
		chk(16'(serial_data_out_oe), 16'h0000);
	endtask

	task automatic wait_rst(input int lim);
		int i;
		for (i = 0; i < lim && system_reset_out_n !== 1'b0; i++) @(posedge mclk);
		chk(16'(system_reset_out_n), 16'h0000);
		for (i = 0; i < 40 && system_reset_out_n !== 1'b1; i++) @(posedge mclk);
		chk(16'(system_reset_out_n), 16'h0001);
		#1;
	endtask

	always @(posedge rx_strobe) begin : watch
		logic [31:0] e;
		e = exp_q.pop_front();
		chk(rx_word & e[31:16], e[15:0]);
	end

	initial begin
		#200us;
		num_errors++;
		wrap_up();
	end

	initial begin
		logic [15:0] cause [4];
		rst_n = 1'b0;
		wd_period_tick = 1'b0;
		irq_src_pulse = 8'h00;
		bus_fault_lvl = 3'h0;
		void'($urandom(32'h1392));
		diag_in = 9'($urandom);
		cause = '{md(scp_pkg::OM_LEAVE_FLASH, 6'h09), hw(2'h0, 1'b0, 1'b1, 12'h000),
			md(3'h0, 6'h09), md(scp_pkg::OM_INIT_NORMAL, 6'h00)};
		repeat (6) @(posedge mclk);
		#1 rst_n = 1'b1;
		wait_rst(2);
		chk(16'(op_mode), 16'(scp_pkg::SCP_STARTUP));
		xfer(md(scp_pkg::OM_INIT_NORMAL, 6'h09), 16, 12'h000, 12'h000);
		chk(16'(op_mode), 16'(scp_pkg::SCP_NORMAL));
		chk(16'(enable_out), 16'h0001);
		chk(16'(sdm_out), 16'h0000);
		chk(16'(wd_period_code), 16'h0009);
		xfer(hw(2'h1, 1'b0, 1'b0, 12'hFFF), 16, 12'h000, 12'h000);
		xfer(hw(2'h1, 1'b0, 1'b1, 12'h000), 16, 12'hFFF, 12'hFFF);
		for (int a = 2; a < 4; a++) begin
			r = 12'($urandom);
			xfer(hw(2'(a), 1'b0, 1'b0, r), 16, 12'h000, 12'h000);
			xfer(hw(2'(a), 1'b0, 1'b1, ~r), 16, 12'hFFF, r);
			xfer(hw(2'(a), 1'b0, 1'b1, r), 16, 12'hFFF, r);
			chk(16'(a == 2 ? setup_ctrl : phy_ctrl), 16'(r));
		end
		chk(16'(phy_ctrl), 16'(r));
		xfer(hw(2'h1, 1'b1, 1'b1, 12'h000), 15, 12'h000, 12'h000);
		chk(16'(irq_out_n_oe), 16'h0001);
		chk(16'(irq_out_n_i), 16'h0000);
		chk(16'(op_mode), 16'(scp_pkg::SCP_NORMAL));
		xfer(hw(2'h1, 1'b1, 1'b1, 12'h000), 16, 12'hFFF, 12'h001);
		bus_fault_lvl = 3'h1;
		repeat (80) @(posedge mclk);
		#1 chk(16'(irq_out_n_oe), 16'h0000);
		repeat (40) @(posedge mclk);
		#1 chk(16'(irq_out_n_oe), 16'h0001);
		xfer(hw(2'h1, 1'b1, 1'b1, 12'h000), 16, 12'hFFF, 12'h002);
		xfer(hw(2'h0, 1'b1, 1'b1, 12'h000), 16, 12'hFFF, {diag_in, bus_fault_lvl});
		// second source pulse in one window is held back, a tick reopens it
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk);
			#1 wd_period_tick = (k == 2);
			@(posedge mclk);
			#1 wd_period_tick = 1'b0;
			irq_src_pulse = 8'h01;
			@(posedge mclk);
			#1 irq_src_pulse = 8'h00;
			xfer(hw(2'h1, 1'b1, 1'b1, 12'h000), 16, 12'hFFF, k == 1 ? 12'h000 : 12'h010);
		end
		for (int k = 0; k < 4; k++) begin
			if (k == 2)
				xfer(md(scp_pkg::OM_INIT_NORMAL, 6'h12), 16, 12'h000, 12'h000);
			fork
				xfer(cause[k], k == 1 ? 17 : 16, 12'h000, 12'h000);
				wait_rst(60);
			join
			chk(16'(op_mode), 16'(scp_pkg::SCP_RESTART));
		end
		for (int a = 1; a < 4; a++) begin
			r = 12'($urandom);
			xfer(hw(2'(a), 1'b0, 1'b0, r), 16, 12'h000, 12'h000);
			xfer(hw(2'(a), 1'b1, 1'b1, 12'h000), 16, 12'hFFF, r);
			if (a == 1)
				chk(16'(special_ctrl), 16'(r));
		end
		xfer(md(scp_pkg::OM_INIT_NORMAL, 6'h09), 16, 12'h000, 12'h000);
		xfer(hw(2'h1, 1'b0, 1'b0, 12'hFFF), 16, 12'h000, 12'h000);
		fork
			xfer(hw(2'h1, 1'b1, 1'b1, 12'h000), 15, 12'h000, 12'h000);
			wait_rst(RDO + 80);
		join
		chk(16'(svc_cnt), 16'h0003);
		wrap_up();
	end
endmodule // sbc_spi_control_port_with_irq_tb
